// ===== inc/ext_op_consts.vh
`ifndef EXT_OP_CONSTS_VH
`define EXT_OP_CONSTS_VH
`define OP_SKIP_NZ 4'h0
`define OP_SUB_ACC 4'h1
`define OP_SUB_MEM 4'h2
`define OP_SWAP 4'h3
`define OP_SWAP_ACC 4'h4
`define OP_SKIP_Z 4'h5
`define OP_SKIP_Z_MOVE 4'h6
`define OP_SKIP_BIT_Z 4'h7
`define OP_TABLE_READ 4'h8
`define OP_XOR_ACC 4'h9
`define OP_XOR_MEM 4'hA
`define FLAG_C 0
`define FLAG_HC 1
`define FLAG_Z 2
`define FLAG_OV 3
`define FLAG_SC 4
`define FLAG_CZ 5
`define SKIP_CYCLES 2'h3
`define PLAIN_CYCLES 2'h1
`endif

// ===== verilog/sub_flags.v
`include "ext_op_consts.vh"
module sub_flags (
  input wire [7:0] acc_in,
  input wire [7:0] mem_in,
  input wire cz_old_in,
  output wire [7:0] diff_out,
  output wire [5:0] flags_out
);
  wire [8:0] wide;
  wire [4:0] low;
  wire [8:0] sgn;
  wire zero;
  assign wide = {1'h0, acc_in} + {1'h0, ~mem_in} + 9'h001;
  assign low = {1'h0, acc_in[3:0]} + {1'h0, ~mem_in[3:0]} + 5'h01;
  assign sgn = {acc_in[7], acc_in} - {mem_in[7], mem_in};
  assign diff_out = wide[7:0];
  assign zero = (wide[7:0] == 8'h00);
  assign flags_out[`FLAG_C] = wide[8];
  assign flags_out[`FLAG_HC] = low[4];
  assign flags_out[`FLAG_Z] = zero;
  assign flags_out[`FLAG_OV] = (acc_in[7] ^ mem_in[7]) &
    (acc_in[7] ^ wide[7]);
  assign flags_out[`FLAG_SC] = sgn[8];
  assign flags_out[`FLAG_CZ] = zero & cz_old_in;
endmodule

// ===== verilog/ext_op_exec.v
`include "ext_op_consts.vh"
module ext_op_exec (
  input wire clk_in,
  input wire nrst_in,
  input wire start_in,
  input wire [3:0] op_in,
  input wire [2:0] bit_sel_in,
  input wire [7:0] mem_rd_in,
  input wire [7:0] acc_in,
  input wire [5:0] flags_in,
  input wire [15:0] prog_word_in,
  input wire [7:0] table_pointer_high_in,
  input wire [7:0] table_pointer_low_in,
  output reg [7:0] acc_out,
  output reg acc_we_out,
  output reg [7:0] mem_wr_out,
  output reg mem_we_out,
  output reg [5:0] flags_out,
  output reg flags_we_out,
  output reg [7:0] table_high_result_out,
  output reg table_high_we_out,
  output reg [15:0] prog_addr_out,
  output reg skip_out,
  output reg busy_out,
  output reg done_out
);
  ////////////////////////////////////////////////////////////////////
  // skip sequence states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SKIP = 2'h1;
  reg rst_a_q;
  reg rst_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [1:0] cnt_q;
  reg [1:0] cnt_d;
  reg [7:0] acc_d;
  reg [7:0] mem_d;
  reg [5:0] flg_d;
  reg acc_we_d;
  reg mem_we_d;
  reg flg_we_d;
  reg th_we_d;
  reg skip_d;
  reg take_d;
  reg busy_d;
  reg done_d;
  wire [7:0] diff;
  wire [5:0] sflags;
  wire [7:0] x;
  wire [7:0] swapped;
  ////////////////////////////////////////////////////////////////////
  // helpers
  function [7:0] nibble_swap;
    input [7:0] value;
    nibble_swap = {value[3:0], value[7:4]};
  endfunction
  function is_zero;
    input [7:0] value;
    is_zero = (value == 8'h00);
  endfunction
  ////////////////////////////////////////////////////////////////////
  // reset release
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_a_q <= 1'h0;
      rst_q <= 1'h0;
    end else begin
      rst_a_q <= 1'h1;
      rst_q <= rst_a_q;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // subtract, xor and nibble swap datapath
  sub_flags u_sub (
    .acc_in(acc_in),
    .mem_in(mem_rd_in),
    .cz_old_in(flags_in[`FLAG_CZ]),
    .diff_out(diff),
    .flags_out(sflags)
  );
  assign x = acc_in ^ mem_rd_in;
  assign swapped = nibble_swap(mem_rd_in);
  ////////////////////////////////////////////////////////////////////
  // decode
  always @* begin
    acc_d = acc_in;
    mem_d = mem_rd_in;
    flg_d = flags_in;
    acc_we_d = 1'h0;
    mem_we_d = 1'h0;
    flg_we_d = 1'h0;
    th_we_d = 1'h0;
    skip_d = 1'h0;
    case (op_in)
      `OP_SKIP_NZ: begin
        mem_we_d = 1'h1;
        skip_d = ~is_zero(mem_rd_in);
      end
      `OP_SUB_ACC: begin
        acc_d = diff;
        acc_we_d = 1'h1;
        flg_d = sflags;
        flg_we_d = 1'h1;
      end
      `OP_SUB_MEM: begin
        mem_d = diff;
        mem_we_d = 1'h1;
        flg_d = sflags;
        flg_we_d = 1'h1;
      end
      `OP_SWAP: begin
        mem_d = swapped;
        mem_we_d = 1'h1;
      end
      `OP_SWAP_ACC: begin
        acc_d = swapped;
        acc_we_d = 1'h1;
      end
      `OP_SKIP_Z: begin
        mem_we_d = 1'h1;
        skip_d = is_zero(mem_rd_in);
      end
      `OP_SKIP_Z_MOVE: begin
        acc_d = mem_rd_in;
        acc_we_d = 1'h1;
        skip_d = is_zero(mem_rd_in);
      end
      `OP_SKIP_BIT_Z: begin
        skip_d = ~mem_rd_in[bit_sel_in];
      end
      `OP_TABLE_READ: begin
        mem_d = prog_word_in[7:0];
        mem_we_d = 1'h1;
        th_we_d = 1'h1;
      end
      `OP_XOR_ACC: begin
        acc_d = x;
        acc_we_d = 1'h1;
        flg_d[`FLAG_Z] = is_zero(x);
        flg_we_d = 1'h1;
      end
      `OP_XOR_MEM: begin
        mem_d = x;
        mem_we_d = 1'h1;
        flg_d[`FLAG_Z] = is_zero(x);
        flg_we_d = 1'h1;
      end
      default: begin
        skip_d = 1'h0;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////
  // skip sequence and dummy slot count
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    take_d = 1'h0;
    busy_d = 1'h0;
    done_d = 1'h0;
    case (state_q)
      ST_IDLE: begin
        if (start_in) begin
          take_d = 1'h1;
          if (skip_d) begin
            state_d = ST_SKIP;
            cnt_d = `SKIP_CYCLES - 2'h1;
            busy_d = 1'h1;
          end else begin
            cnt_d = 2'h0;
            done_d = 1'h1;
          end
        end
      end
      ST_SKIP: begin
        busy_d = 1'h1;
        cnt_d = cnt_q - 2'h1;
        if (cnt_q == 2'h1) begin
          state_d = ST_IDLE;
          busy_d = 1'h0;
          done_d = 1'h1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d = 2'h0;
      end
    endcase
  end
  always @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      state_q <= ST_IDLE;
      cnt_q <= 2'h0;
      busy_out <= 1'h0;
      done_out <= 1'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      busy_out <= busy_d;
      done_out <= done_d;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // results
  always @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      acc_out <= 8'h00;
      acc_we_out <= 1'h0;
      mem_wr_out <= 8'h00;
      mem_we_out <= 1'h0;
      flags_out <= 6'h00;
      flags_we_out <= 1'h0;
      table_high_we_out <= 1'h0;
      skip_out <= 1'h0;
    end else begin
      acc_we_out <= 1'h0;
      mem_we_out <= 1'h0;
      flags_we_out <= 1'h0;
      table_high_we_out <= 1'h0;
      if (take_d) begin
        acc_out <= acc_d;
        acc_we_out <= acc_we_d;
        mem_wr_out <= mem_d;
        mem_we_out <= mem_we_d;
        flags_out <= flg_d;
        flags_we_out <= flg_we_d;
        table_high_we_out <= th_we_d;
        skip_out <= skip_d;
      end
    end
  end
  always @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      table_high_result_out <= 8'h00;
    end else if (take_d && th_we_d) begin
      table_high_result_out <= prog_word_in[15:8];
    end
  end
  ////////////////////////////////////////////////////////////////////
  // table pointer to program address
  always @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      prog_addr_out <= 16'h0000;
    end else begin
      prog_addr_out <= {table_pointer_high_in, table_pointer_low_in};
    end
  end
endmodule

// ===== verif/ext_op_exec_properties.sv
`include "ext_op_consts.vh"
module ext_op_exec_properties (
  input wire clk_in,
  input wire nrst_in,
  input wire start_in,
  input wire [3:0] op_in,
  input wire [2:0] bit_sel_in,
  input wire [7:0] mem_rd_in,
  input wire [7:0] acc_in,
  input wire [7:0] acc_out,
  input wire [7:0] mem_wr_out,
  input wire mem_we_out,
  input wire [5:0] flags_out,
  input wire flags_we_out,
  input wire skip_out,
  input wire busy_out,
  input wire done_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  wire t = start_in && !busy_out;
  wire [7:0] sw = {mem_rd_in[3:0], mem_rd_in[7:4]};
  wire bv = mem_rd_in[bit_sel_in];
  wire [7:0] xr = acc_in ^ mem_rd_in;
  sequence s_take_skip;
    t && op_in == `OP_SKIP_Z && mem_rd_in == 8'h00;
  endsequence
  sequence s_dummy_slot;
    busy_out [*2] ##1 (!busy_out && done_out);
  endsequence
  a_skip_three: assert property (s_take_skip |=> s_dummy_slot)
    else $error("skip length");
  a_skip_nz: assert property (t && op_in == `OP_SKIP_NZ |=>
    mem_we_out && !flags_we_out && mem_wr_out == $past(mem_rd_in) &&
    skip_out == ($past(mem_rd_in) != 8'h00)) else $error("skip nz");
  a_bit_skip: assert property (t && op_in == `OP_SKIP_BIT_Z |=>
    skip_out == !$past(bv) && !flags_we_out) else $error("bit skip");
  a_swap_mem: assert property (t && op_in == `OP_SWAP |=>
    mem_we_out && mem_wr_out == $past(sw)) else $error("swap mem");
  a_swap_acc: assert property (t && op_in == `OP_SWAP_ACC |=>
    !mem_we_out && acc_out == $past(sw)) else $error("swap acc");
  a_sub_carry: assert property (t && op_in inside {1, 2} |=>
    flags_out[0] == ($past(acc_in) >= $past(mem_rd_in))) else $error("carry");
  a_xor_acc: assert property (t && op_in == `OP_XOR_ACC |=>
    acc_out == $past(xr)) else $error("xor acc");
  a_xor_mem: assert property (t && op_in == `OP_XOR_MEM |=>
    mem_wr_out == $past(xr) && flags_out[2] == !$past(xr)) else $error("xm");
endmodule

// ===== verif/ext_memory_op_subset_tb_top.sv
`include "ext_op_consts.vh"
module ext_memory_op_subset_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = '0, nrst_in = '0, start_in = '0;
  logic [3:0] op_in = '0;
  logic [2:0] bit_sel_in = '0;
  logic [7:0] mem_rd_in = '0, acc_in = '0;
  logic [7:0] table_pointer_high_in = '0, table_pointer_low_in = '0;
  logic [5:0] flags_in = '0, flags_out;
  logic [7:0] acc_out, mem_wr_out, table_high_result_out;
  logic [15:0] prog_addr_out;
  logic acc_we_out, mem_we_out, flags_we_out, table_high_we_out;
  logic skip_out, busy_out, done_out;
  wire [15:0] prog_word_in = prog_addr_out ^ 16'hA5C3;
  localparam [10:0] ACW = 11'h252, MEW = 11'h52D, FW = 11'h606;
  int failures = 0, n_checks = 0;
  always #20 clk_in = ~clk_in;
  ext_op_exec DUT (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .start_in(start_in),
    .op_in(op_in),
    .bit_sel_in(bit_sel_in),
    .mem_rd_in(mem_rd_in),
    .acc_in(acc_in),
    .flags_in(flags_in),
    .prog_word_in(prog_word_in),
    .table_pointer_high_in(table_pointer_high_in),
    .table_pointer_low_in(table_pointer_low_in),
    .acc_out(acc_out),
    .acc_we_out(acc_we_out),
    .mem_wr_out(mem_wr_out),
    .mem_we_out(mem_we_out),
    .flags_out(flags_out),
    .flags_we_out(flags_we_out),
    .table_high_result_out(table_high_result_out),
    .table_high_we_out(table_high_we_out),
    .prog_addr_out(prog_addr_out),
    .skip_out(skip_out),
    .busy_out(busy_out),
    .done_out(done_out)
  );
  task automatic chk(input string n, input logic [15:0] g, e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [8:0] want(logic [3:0] o, logic [7:0] m, a, p,
                                      logic [2:0] b);
    case (o)
      1, 2: return {1'h0, a - m};
      3, 4: return {1'h0, m[3:0], m[7:4]};
      8: return {1'h0, p ^ 8'hC3};
      9, 10: return {1'h0, a ^ m};
      0: return {m != 8'h00, m};
      7: return {!m[b], m};
      default: return {m == 8'h00, m};
    endcase
  endfunction
  function automatic logic [5:0] sub_want(logic [7:0] a, m, logic cz);
    int d;
    logic [5:0] r;
    d = $signed(a) - $signed(m);
    r[`FLAG_C] = a >= m;
    r[`FLAG_HC] = a[3:0] >= m[3:0];
    r[`FLAG_Z] = a == m;
    r[`FLAG_OV] = d > 127 || d < -128;
    r[`FLAG_SC] = d < 0;
    r[`FLAG_CZ] = a == m && cz;
    return r;
  endfunction
  task automatic run(logic [3:0] o, logic [7:0] m, a);
    logic [15:0] p = $urandom;
    logic [5:0] f = $urandom;
    logic [2:0] b = $urandom;
    logic [8:0] x;
    int w = 0;
    x = want(o, m, a, p[7:0], b);
    @(posedge clk_in);
    {table_pointer_high_in, table_pointer_low_in} <= p;
    @(posedge clk_in);
    {start_in, op_in, mem_rd_in, acc_in, flags_in} <= {1'h1, o, m, a, f};
    bit_sel_in <= b;
    @(posedge clk_in);
    start_in <= 1'h0;
    #1;
    chk("skip", skip_out, x[8]);
    chk("acc_we", acc_we_out, ACW[o]);
    chk("mem_we", mem_we_out, MEW[o]);
    chk("flags_we", flags_we_out, FW[o]);
    if (ACW[o]) chk("acc", acc_out, x[7:0]);
    if (MEW[o]) chk("mem", mem_wr_out, x[7:0]);
    if (FW[o]) chk("zero", flags_out[2], x[7:0] == 8'h00);
    if (o == 1 || o == 2) chk("carry", flags_out[0], a >= m);
    if (o == 1 || o == 2)
      chk("sub_flags", flags_out, sub_want(a, m, f[5]));
    chk("high_we", table_high_we_out, o == 8);
    chk("busy", busy_out, x[8]);
    if (o > 8) chk("flags", flags_out, {f[5:3], !x[7:0], f[1:0]});
    if (o == 8) chk("high", table_high_result_out, p[15:8] ^ 8'hA5);
    chk("done", done_out, !x[8]);
    while (x[8] && !done_out && w < 9) begin
      @(posedge clk_in);
      #1;
      w++;
    end
    if (x[8]) chk("skip_len", w, 2);
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hE766));
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'h1;
    repeat (3) @(posedge clk_in);
    for (int o = 0; o < 11; o++) begin
      run(o, 8'h00, 8'h00);
      run(o, 8'h80, 8'h01);
      run(o, 8'h01, 8'h80);
    end
    repeat (300) run($urandom % 11, $urandom, $urandom);
    complete_run;
  end
  // about 1100 cycles expected, limit well above
  initial begin
    #1000000;
    failures++;
    complete_run;
  end
endmodule
bind ext_op_exec ext_op_exec_properties chk_i (.clk_in, .nrst_in,
  .start_in, .op_in, .bit_sel_in, .mem_rd_in, .acc_in, .acc_out,
  .mem_wr_out, .mem_we_out, .flags_out, .flags_we_out, .skip_out,
  .busy_out, .done_out);
